// ---- pkg/aas_pkg.sv ----
// Constants shared by the acquisition sequencer and its result FIFO.
// Assumes a 100 MHz system clock and a 32-bit Wishbone register bus.
package aas_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0] TICK_RELOAD = 7'(TICK_CYCLES - 1);
    localparam int unsigned DATA_W = 12;
    localparam int unsigned FIFO_DEPTH = 1024;
    localparam int unsigned FIFO_AW = 10;
    localparam logic [10:0] FIFO_FULL = 11'h400;
    localparam logic [10:0] FIFO_HALF = 11'h200;
    localparam int unsigned ADR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SIVL = 8'h04;
    localparam logic [7:0] OFS_SCNT = 8'h08;
    localparam logic [7:0] OFS_ICYC = 8'h0c;
    localparam logic [7:0] OFS_IPER = 8'h10;
    localparam logic [7:0] OFS_MODE = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;
    localparam logic [7:0] OFS_DATA = 8'h1c;
    localparam logic [7:0] OFS_CLR = 8'h20;
    localparam logic [7:0] MODE2_CODE = 8'h34;
    localparam int unsigned C_SW = 0;
    localparam int unsigned C_HW = 1;
    localparam int unsigned C_PRE = 2;
    localparam int unsigned C_CTL = 3;
    localparam int unsigned C_XDIS = 4;
    localparam int unsigned C_ISCAN = 5;
    localparam int unsigned C_XISEL = 6;
    localparam int unsigned C_IE_DAV = 8;
    localparam int unsigned C_IE_HF = 9;
    localparam int unsigned C_IE_ERR = 10;
    localparam int unsigned C_IE_DONE = 11;
    localparam logic [15:0] CTRL_RST = 16'h0010;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [7:0] IPER_RST = 8'h00;
    localparam int unsigned S_DAV = 0;
    localparam int unsigned S_HF_N = 1;
    localparam int unsigned S_OVF = 2;
    localparam int unsigned S_OVR = 3;
    localparam int unsigned S_DONE = 4;
    localparam int unsigned S_RUN = 5;
    localparam int unsigned S_ARMED = 6;
    localparam int unsigned S_CNT_LSB = 16;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b10,
        ST_POST = 2'b11
    } aas_state_type;
endpackage

// ---- src/aas_fifo.sv ----
// Result FIFO of 1024 converter words with occupancy count.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module aas_fifo (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [aas_pkg::DATA_W-1:0] data_i,
    input wire logic pop_i,
    output logic [aas_pkg::DATA_W-1:0] data_o,
    output logic [10:0] count_o,
    output logic empty_o,
    output logic overflow_o
);
    import aas_pkg::*;
    logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [10:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    always_comb begin
        do_pop = pop_i && (cnt_q != 11'h000);
        do_push = push_i && (cnt_q != FIFO_FULL) && !flush_i;
        // A word offered while all entries are held is lost.
        overflow_o = push_i && (cnt_q == FIFO_FULL) && !flush_i;
        wr_d = wr_q + FIFO_AW'(do_push);
        rd_d = rd_q + FIFO_AW'(do_pop);
        cnt_d = cnt_q + 11'(do_push) - 11'(do_pop);
        if (flush_i) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem_q[wr_q] <= data_i;
        end
    end

    assign data_o = mem_q[rd_q];
    assign count_o = cnt_q;
    assign empty_o = (cnt_q == 11'h000);
endmodule
`default_nettype wire

// ---- src/aas_top.sv ----
// Acquisition sequencer: trigger control, conversion pacing, error flags.
// Assumes a Wishbone classic master and an external converter on clk_i.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Software trigger set starts pacing; clearing it stops the acquisition.
// - A result offered to a full 1024-entry FIFO sets the overflow flag.
// - Starting a conversion while the converter is busy sets the overrun flag.
// - In posttrigger mode the external trigger replaces the software trigger.
// - Mode code 0x34 holds the interval output high; external strobes then enabled.
// - Hardware trigger enabled: next rising edge starts; later edges ignored.
// - Clearing hardware trigger then clear register stops and flushes data.
// - Pretrigger: external edge after start gates counting of N+1 samples.
// - Pretrigger acquisition ends when the sample count expires.
// - The first interval cycle is not aligned with the interval counter.
// - Data-available enable raises the interrupt while the FIFO holds data.
// - Half-full enable raises the interrupt once 512 samples are held.
// - Error enable raises the interrupt while overflow or overrun is set.
// - Done enable raises the interrupt when the sample counter terminates.
// - Outside interval scan, each expiry of the sample interval counter starts one conversion unless the converter is busy.
// - A controlled acquisition takes N+2 samples.
module aas_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [aas_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_trigger_input_i,
    input wire logic external_conversion_strobe_n_i,
    input wire logic interval_pulse_line_i,
    input wire logic adc_busy_i,
    input wire logic adc_valid_i,
    input wire logic [aas_pkg::DATA_W-1:0] adc_data_i,
    output logic conv_start_o,
    output logic irq_o
);
    import aas_pkg::*;

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic [15:0] ctrl_q, ctrl_d, sivl_q, sivl_d, scnt_q, scnt_d, icyc_q, icyc_d;
    logic [15:0] sicnt_q, sicnt_d, icnt_q, icnt_d;
    logic [7:0] iper_q, iper_d, iconv_q, iconv_d;
    logic [16:0] remain_q, remain_d;
    logic [6:0] tick_q, tick_d;
    logic [31:0] rdat_q, rdat_d;
    logic [2:0] sync1_q, sync2_q, prev_q;
    aas_state_type state_q, state_d;
    logic mode2_q, mode2_d, skip_q, skip_d, hws_q, hws_d;
    logic ovf_q, ovf_d, ovr_q, ovr_d, done_q, done_d;
    logic conv_q, conv_d, irq_q, irq_d, ack_q, ack_d;
    logic acc, tick, pop, clr_w, start, stop, int_ev, ext_ev, pace, bound, counting;
    logic trig_rise, conv_fall, ipulse_rise, hf_n;
    logic [DATA_W-1:0] fifo_dout;
    logic [10:0] fifo_cnt;
    logic fifo_empty, fifo_ovf;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    aas_fifo u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(clr_w),
        .push_i(adc_valid_i),
        .data_i(adc_data_i),
        .pop_i(pop),
        .data_o(fifo_dout),
        .count_o(fifo_cnt),
        .empty_o(fifo_empty),
        .overflow_o(fifo_ovf)
    );

    assign acc = wb_cyc_i && wb_stb_i && !ack_q;
    assign tick = (tick_q == 7'h00);
    assign trig_rise = sync2_q[0] && !prev_q[0];
    assign conv_fall = !sync2_q[1] && prev_q[1];
    assign ipulse_rise = sync2_q[2] && !prev_q[2];
    assign hf_n = (fifo_cnt < FIFO_HALF);

    // ********************************************************************
    // Register access and sequencer
    // ********************************************************************
    always_comb begin
        ctrl_d = ctrl_q;
        sivl_d = sivl_q;
        scnt_d = scnt_q;
        icyc_d = icyc_q;
        iper_d = iper_q;
        mode2_d = mode2_q;
        state_d = state_q;
        remain_d = remain_q;
        sicnt_d = sicnt_q;
        icnt_d = icnt_q;
        iconv_d = iconv_q;
        skip_d = skip_q;
        hws_d = hws_q;
        ovf_d = ovf_q;
        ovr_d = ovr_q;
        done_d = done_q;
        conv_d = 1'b0;
        rdat_d = rdat_q;
        ack_d = acc;
        pop = 1'b0;
        clr_w = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        int_ev = 1'b0;
        bound = 1'b0;
        pace = 1'b0;
        counting = 1'b0;
        ext_ev = 1'b0;
        tick_d = tick ? TICK_RELOAD : tick_q - 7'h01;
        if (acc && wb_we_i) begin
            unique case (wb_adr_i)
                OFS_CTRL: ctrl_d = merge16(ctrl_q, wb_dat_i, wb_sel_i);
                OFS_SIVL: sivl_d = merge16(sivl_q, wb_dat_i, wb_sel_i);
                OFS_SCNT: scnt_d = merge16(scnt_q, wb_dat_i, wb_sel_i);
                OFS_ICYC: icyc_d = merge16(icyc_q, wb_dat_i, wb_sel_i);
                OFS_IPER: iper_d = wb_sel_i[0] ? wb_dat_i[7:0] : iper_q;
                OFS_MODE: begin
                    // Mode 2 stops internal pacing with the output held high.
                    if (wb_sel_i[0]) begin
                        mode2_d = (wb_dat_i[7:0] == MODE2_CODE);
                        if (wb_dat_i[7:0] == MODE2_CODE) begin
                            sivl_d = CNT_RST;
                        end
                    end
                end
                OFS_CLR: clr_w = 1'b1;
                default: ;
            endcase
        end
        if (acc && !wb_we_i) begin
            rdat_d = 32'h0000_0000;
            unique case (wb_adr_i)
                OFS_CTRL: rdat_d[15:0] = ctrl_q;
                OFS_SIVL: rdat_d[15:0] = sivl_q;
                OFS_SCNT: rdat_d[15:0] = scnt_q;
                OFS_ICYC: rdat_d[15:0] = icyc_q;
                OFS_IPER: rdat_d[7:0] = iper_q;
                OFS_MODE: rdat_d[7:0] = mode2_q ? MODE2_CODE : 8'h00;
                OFS_STAT: begin
                    rdat_d[S_DAV] = !fifo_empty;
                    rdat_d[S_HF_N] = hf_n;
                    rdat_d[S_OVF] = ovf_q;
                    rdat_d[S_OVR] = ovr_q;
                    rdat_d[S_DONE] = done_q;
                    rdat_d[S_RUN] = state_q[1];
                    rdat_d[S_ARMED] = (state_q == ST_ARMED);
                    rdat_d[S_CNT_LSB +: 11] = fifo_cnt;
                end
                OFS_DATA: begin
                    rdat_d[DATA_W-1:0] = fifo_dout;
                    pop = 1'b1;
                end
                default: ;
            endcase
        end
        unique case (state_q)
            ST_IDLE: begin
                if (ctrl_d[C_SW] && !ctrl_q[C_SW] && !ctrl_d[C_HW]) begin
                    start = 1'b1;
                    hws_d = 1'b0;
                end else if (ctrl_d[C_HW] && !ctrl_q[C_HW] && !ctrl_d[C_PRE]) begin
                    state_d = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!ctrl_d[C_HW]) begin
                    state_d = ST_IDLE;
                end else if (trig_rise) begin
                    start = 1'b1;
                    hws_d = 1'b1;
                end
            end
            ST_RUN, ST_POST: begin
                if (tick && sivl_q > 16'h0001) begin
                    if (sicnt_q <= 16'h0001) begin
                        sicnt_d = sivl_q;
                        int_ev = 1'b1;
                    end else begin
                        sicnt_d = sicnt_q - 16'h0001;
                    end
                end
                ext_ev = conv_fall && !ctrl_q[C_XDIS] && mode2_q;
                if (ext_ev) begin
                    skip_d = 1'b0;
                end
                if (ctrl_q[C_ISCAN]) begin
                    // The first cycle runs from the start, not from a boundary.
                    if (ctrl_q[C_XISEL]) begin
                        bound = ipulse_rise;
                    end else if (tick) begin
                        bound = (icnt_q <= 16'h0001);
                        icnt_d = bound ? icyc_q : icnt_q - 16'h0001;
                    end
                end
                pace = (int_ev || (ext_ev && !skip_q)) && (!ctrl_q[C_ISCAN] || iconv_q != 8'h00);
                // After the pretrigger edge the count always runs, controlled bit or not.
                counting = (state_q == ST_POST) || (ctrl_q[C_CTL] && !ctrl_q[C_PRE]);
                if (pace) begin
                    if (ctrl_q[C_ISCAN]) begin
                        iconv_d = iconv_q - 8'h01;
                    end
                    if (!adc_busy_i) begin
                        conv_d = 1'b1;
                        if (counting) begin
                            remain_d = remain_q - 17'h00001;
                            stop = (remain_q == 17'h00001);
                        end
                    end
                end
                if (bound) begin
                    iconv_d = iper_q;
                end
                if (state_q == ST_RUN && ctrl_q[C_PRE] && trig_rise) begin
                    state_d = ST_POST;
                    remain_d = {1'b0, scnt_q} + 17'h00001;
                end
                if (stop) begin
                    state_d = ST_IDLE;
                    done_d = 1'b1;
                end
                if (!ctrl_d[C_SW] && ctrl_q[C_SW] && !hws_q) begin
                    state_d = ST_IDLE;
                end
                if (!ctrl_d[C_HW] && ctrl_q[C_HW] && hws_q) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
        if (start) begin
            state_d = ST_RUN;
            remain_d = {1'b0, scnt_q} + 17'h00002;
            sicnt_d = sivl_q;
            icnt_d = icyc_q;
            iconv_d = iper_q;
            skip_d = 1'b1;
            done_d = 1'b0;
        end
        if (clr_w) begin
            state_d = ST_IDLE;
            ovf_d = 1'b0;
            ovr_d = 1'b0;
            done_d = 1'b0;
        end
        // Sets follow the clear so that a same-cycle overrun is kept; the flush masks a same-cycle overflow.
        if (fifo_ovf) begin
            ovf_d = 1'b1;
        end
        if (pace && adc_busy_i) begin
            ovr_d = 1'b1;
        end
        irq_d = (ctrl_q[C_IE_DAV] && !fifo_empty)
             || (ctrl_q[C_IE_HF] && !hf_n)
             || (ctrl_q[C_IE_ERR] && (ovf_q || ovr_q))
             || (ctrl_q[C_IE_DONE] && done_q);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RST;
            sivl_q <= CNT_RST;
            scnt_q <= CNT_RST;
            icyc_q <= CNT_RST;
            iper_q <= IPER_RST;
            sicnt_q <= CNT_RST;
            icnt_q <= CNT_RST;
            iconv_q <= IPER_RST;
            remain_q <= '0;
            tick_q <= TICK_RELOAD;
            rdat_q <= '0;
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q <= '0;
            state_q <= ST_IDLE;
            {mode2_q, skip_q, hws_q, ovf_q, ovr_q, done_q} <= '0;
            {conv_q, irq_q, ack_q} <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            sivl_q <= sivl_d;
            scnt_q <= scnt_d;
            icyc_q <= icyc_d;
            iper_q <= iper_d;
            sicnt_q <= sicnt_d;
            icnt_q <= icnt_d;
            iconv_q <= iconv_d;
            remain_q <= remain_d;
            tick_q <= tick_d;
            rdat_q <= rdat_d;
            sync1_q <= {interval_pulse_line_i, external_conversion_strobe_n_i,
                        external_trigger_input_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            state_q <= state_d;
            {mode2_q, skip_q, hws_q, ovf_q, ovr_q, done_q} <=
                {mode2_d, skip_d, hws_d, ovf_d, ovr_d, done_d};
            {conv_q, irq_q, ack_q} <= {conv_d, irq_d, ack_d};
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign conv_start_o = conv_q;
    assign irq_o = irq_q;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sw_stop_a: assert property (
        $fell(ctrl_q[C_SW]) && $past(state_q[1]) && !$past(hws_q) |-> state_q == ST_IDLE)
        else $error("software trigger clear did not stop acquisition");
    ovf_set_a: assert property (
        fifo_ovf |=> ovf_q && fifo_cnt == FIFO_FULL || $past(pop))
        else $error("overflow flag not set on lost result");
    ovr_set_a: assert property (
        pace && adc_busy_i |=> ovr_q && !conv_q)
        else $error("overrun not flagged or conversion issued while busy");
    hw_start_a: assert property (
        state_q == ST_ARMED && trig_rise && ctrl_d[C_HW] && !clr_w |=> state_q == ST_RUN && hws_q)
        else $error("external trigger edge did not start acquisition");
    skip_first_a: assert property (
        state_q[1] && skip_q && ext_ev && !int_ev |=> !conv_q)
        else $error("first external strobe produced a conversion");
    clr_flush_a: assert property (
        clr_w && !adc_valid_i |=> fifo_empty && !ovf_q && state_q == ST_IDLE)
        else $error("clear did not discard data");
    pre_gate_a: assert property (
        state_q == ST_RUN && ctrl_q[C_PRE] && trig_rise && !clr_w && !stop
        |=> remain_q == {1'b0, $past(scnt_q)} + 17'h00001)
        else $error("pretrigger edge did not load N+1");
    count_end_a: assert property (
        conv_d && counting && remain_q == 17'h00001 && !clr_w |=> done_q ##1 state_q == ST_IDLE)
        else $error("acquisition did not end at count expiry");
    ctl_load_a: assert property (
        start && !clr_w |=> remain_q == {1'b0, $past(scnt_q)} + 17'h00002)
        else $error("controlled count not loaded with N+2");
    int_conv_a: assert property (
        int_ev && !ctrl_q[C_ISCAN] && !adc_busy_i |=> conv_q)
        else $error("interval expiry started no conversion");
    irq_dav_a: assert property (
        ctrl_q[C_IE_DAV] && !fifo_empty && $stable(ctrl_q) |=> irq_o)
        else $error("data-available interrupt missing");
    irq_hf_a: assert property (
        ctrl_q[C_IE_HF] && fifo_cnt >= FIFO_HALF && $stable(ctrl_q) |=> irq_o)
        else $error("half-full interrupt missing");
    irq_err_a: assert property (
        ctrl_q[C_IE_ERR] && (ovf_q || ovr_q) && $stable(ctrl_q) |=> irq_o)
        else $error("error interrupt missing");
    irq_done_a: assert property (
        ctrl_q[C_IE_DONE] && done_q && $stable(ctrl_q) |=> irq_o)
        else $error("done interrupt missing");
    err_hold_a: assert property (
        ovr_q && !clr_w |=> ovr_q)
        else $error("overrun flag dropped without clear");
    bus_ack_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    post_run_c: cover property (state_q == ST_ARMED ##[1:200] state_q == ST_RUN);
    pre_end_c: cover property (state_q == ST_POST ##[1:1000] done_q);
    ovr_c: cover property (pace && adc_busy_i);
endmodule
`default_nettype wire

// ---- tb/aas_adc_model.sv ----
// Behavioural converter that answers the sequencer's conversion starts.
// Assumes start pulses come on the same clock as the sequencer.
`timescale 1ns/1ps
`default_nettype none
module aas_adc_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic slow_i,
    output logic busy_o,
    output logic valid_o,
    output logic [aas_pkg::DATA_W-1:0] data_o
);
    import aas_pkg::*;
    int left;
    logic [DATA_W-1:0] seq_q;
    // Outside the valid pulse the data lines carry no stale result.
    assign data_o = valid_o ? seq_q : ~seq_q;
    always @(posedge clk_i) begin
        if (rst_i) begin
            left <= 0;
            busy_o <= 1'b0;
            valid_o <= 1'b0;
            seq_q <= '0;
        end else if (left == 0 && start_i) begin
            left <= slow_i ? 300 : 20;
            busy_o <= 1'b1;
            valid_o <= 1'b0;
        end else if (left == 1) begin
            left <= 0;
            busy_o <= 1'b0;
            valid_o <= 1'b1;
            seq_q <= seq_q + 1'b1;
        end else begin
            valid_o <= 1'b0;
            if (left > 1) left <= left - 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_aas_top.sv ----
// Self-checking bench for the acquisition sequencer.
// Assumes a converter model on the far side and a Wishbone classic master here.
`timescale 1ns/1ps
`default_nettype none
module tb_aas_top;
    import aas_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic trig = 1'b0;
    logic xconv = 1'b1;
    logic ipulse = 1'b0;
    logic slow = 1'b0;
    logic [31:0] rdat;
    logic [31:0] dat_o;
    logic ack, start, irq, busy, valid;
    logic [DATA_W-1:0] adata;
    int n_mismatch = 0;
    int checks = 0;
    int n_conv = 0;
    int cyc_n = 0;
    int c;
    aas_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .external_trigger_input_i(trig), .external_conversion_strobe_n_i(xconv),
        .interval_pulse_line_i(ipulse), .adc_busy_i(busy), .adc_valid_i(valid),
        .adc_data_i(adata), .conv_start_o(start), .irq_o(irq));
    aas_adc_model i_adc (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .slow_i(slow),
        .busy_o(busy), .valid_o(valid), .data_o(adata));
    // ************************************************************
    // Bus, timing and comparison helpers
    // ************************************************************
    initial forever #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n++;
        if (start === 1'b1) n_conv++;
        // The whole run needs about 31000 cycles; a hang ends it here.
        if (cyc_n == 60000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        rdat = dat_o;
        cyc <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic pulse_trig();
        trig <= 1'b1;
        idle(5);
        trig <= 1'b0;
    endtask
    task automatic strobe();
        xconv <= 1'b0;
        idle(4);
        xconv <= 1'b1;
        idle(40);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        wb(1'b0, OFS_CTRL, 32'h0);
        chk(rdat, {16'h0, CTRL_RST});
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat, 32'h2);
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0);
        chk(irq, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_ctrl();
        wb(1'b1, OFS_SIVL, 32'h2);
        wb(1'b1, OFS_SCNT, 32'h1);
        n_conv = 0;
        wb(1'b1, OFS_CTRL, 32'h0809);
        idle(1000);
        chk(32'(n_conv), 32'h3);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[S_DONE], 1'b1);
        chk(rdat[26:16], 11'h003);
        chk(irq, 1'b1);
        wb(1'b0, OFS_DATA, 32'h0);
        chk(rdat[11:0], 12'h001);
        wb(1'b1, OFS_CTRL, 32'h0);
        $display("test controlled done");
    endtask
    task automatic t_hw();
        wb(1'b1, OFS_CLR, 32'h0);
        n_conv = 0;
        wb(1'b1, OFS_CTRL, 32'h000a);
        idle(300);
        chk(32'(n_conv), 32'h0);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[S_ARMED], 1'b1);
        pulse_trig();
        idle(1000);
        chk(32'(n_conv), 32'h3);
        pulse_trig();
        idle(1000);
        chk(32'(n_conv), 32'h3);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_CLR, 32'h0);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[26:16], 11'h000);
        chk(rdat[S_DAV], 1'b0);
        $display("test hardware trigger done");
    endtask
    task automatic t_pre();
        wb(1'b1, OFS_SCNT, 32'h2);
        wb(1'b1, OFS_CTRL, 32'h0005);
        idle(700);
        c = n_conv;
        pulse_trig();
        idle(1500);
        chk(32'(n_conv - c), 32'h3);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[S_RUN], 1'b0);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_CLR, 32'h0);
        $display("test pretrigger done");
    endtask
    task automatic t_ovr();
        slow <= 1'b1;
        wb(1'b1, OFS_CTRL, 32'h0401);
        idle(1000);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[S_OVR], 1'b1);
        chk(irq, 1'b1);
        wb(1'b1, OFS_CTRL, 32'h0400);
        idle(400);
        c = n_conv;
        idle(1000);
        chk(32'(n_conv), 32'(c));
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[S_OVR], 1'b1);
        wb(1'b1, OFS_CLR, 32'h0);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[S_OVR], 1'b0);
        chk(irq, 1'b0);
        slow <= 1'b0;
        $display("test overrun done");
    endtask
    task automatic t_ext();
        wb(1'b1, OFS_MODE, 32'h34);
        wb(1'b1, OFS_IPER, 32'h1);
        c = n_conv;
        wb(1'b1, OFS_CTRL, 32'h0161);
        repeat (2) strobe();
        chk(32'(n_conv - c), 32'h1);
        strobe();
        chk(32'(n_conv - c), 32'h1);
        ipulse <= 1'b1;
        idle(4);
        ipulse <= 1'b0;
        strobe();
        chk(32'(n_conv - c), 32'h2);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[26:16], 11'h002);
        chk(irq, 1'b1);
        wb(1'b0, OFS_DATA, 32'h0);
        wb(1'b0, OFS_STAT, 32'h0);
        chk(rdat[26:16], 11'h001);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_CTRL, 32'h0201);
        repeat (511) strobe();
        chk(irq, 1'b0);
        strobe();
        chk(irq, 1'b1);
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b1, OFS_CLR, 32'h0);
        $display("test external timing done");
    endtask
    initial begin
        idle(2);
        rst_i <= 1'b0;
        t_reset();
        t_ctrl();
        t_hw();
        t_pre();
        t_ovr();
        t_ext();
        print_verdict();
    end
endmodule
`default_nettype wire
